// ### rtl/smtm_core.sv
// measurement engine of the signal measurement timer, apb register slave
// assumes pins come from other domains; apb runs on ref_clk
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module smtm_core
  import smtm_pkg::*;
#(
  parameter int unsigned CNT_W = CNT_W_DEF
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic measured_signal_input,
  input wire logic window_input,
  input wire logic meas_clk_in,
  output logic width_capture_irq,
  output logic period_capture_irq,
  output logic match_irq
);

  if (CNT_W <= SHORT_W || CNT_W > 24) begin : g_bad_width
    $error("CNT_W must lie in 17..24");
  end

  // ****************************************
  // registers
  // ****************************************
  smtm_ctrl0_t c0_q;
  logic go_q, repeat_q, short_q;
  logic [3:0] mode_q;
  logic [CNT_W-1:0] cnt_q, cnt_d, wid_q, per_q, lim_q;
  logic [2:0] flags_q, flags_d, allow_q;
  logic [31:0] prdata_q, rd_mux;
  logic pready_q, pslverr_q;
  logic [2:0] irq_q;
  smtm_state_t state_q, state_d;

  // ****************************************
  // apb decode
  // ****************************************
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready_q;
  wire wr = acc & pwrite;
  wire wr_c0 = wr & (paddr == OFS_CTRL0);
  wire wr_c1 = wr & (paddr == OFS_CTRL1);
  wire wr_st = wr & (paddr == OFS_STAT);
  wire wr_cnt = wr & (paddr == OFS_COUNT);
  wire wr_lim = wr & (paddr == OFS_LIMIT);
  wire wr_flg = wr & (paddr == OFS_FLAGS);
  wire wr_alw = wr & (paddr == OFS_ALLOW);
  wire hit = (paddr <= OFS_ALLOW) & (paddr[1:0] == 2'h0);
  // manual requests act at once, so the bits read back as zero
  wire man_rst = wr_st & pwdata[ST_RST];
  wire man_cpw = wr_st & pwdata[ST_CPWUP];
  wire man_cpr = wr_st & pwdata[ST_CPRUP];
  wire cnt_sw = wr_cnt | man_rst;
  wire en = c0_q.enable;

  // ****************************************
  // input synchronisers and polarity
  // ****************************************
  logic [2:0] sync1_q, sync2_q, prev_q;
  wire [2:0] pin_raw = {meas_clk_in, window_input, measured_signal_input};
  // (RL26) two-stage synchroniser
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  // (RL3) polarity inversion
  wire [2:0] pol = sync2_q ^ {c0_q.clock_invert, c0_q.window_invert, c0_q.signal_invert};
  wire s = pol[0];
  wire w = pol[1];

  // ****************************************
  // prescaler: measurement tick enable
  // ****************************************
  logic clk_prev_q;
  logic [2:0] ps_cnt_q;
  wire clk_edge = pol[2] & ~clk_prev_q;
  wire [2:0] ps_max = 3'((4'h1 << c0_q.prescale) - 4'h1);
  wire meas_tick = en & clk_edge & (ps_cnt_q == ps_max);

  // (RL25) disable clears the divider
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_prev_q <= 1'b0;
      ps_cnt_q <= 3'h0;
    end else begin
      clk_prev_q <= pol[2];
      if (!en) ps_cnt_q <= 3'h0;
      else if (clk_edge) ps_cnt_q <= (ps_cnt_q == ps_max) ? 3'h0 : ps_cnt_q + 3'h1;
    end
  end

  // ****************************************
  // edge detection per mode class
  // ****************************************
  // (RL6) sync modes sample on tick only
  wire sync_mode = ~mode_q[3];
  wire step = en & (sync_mode ? meas_tick : 1'b1);
  wire sig_rise = step & s & ~prev_q[0];
  wire sig_fall = step & ~s & prev_q[0];
  wire win_rise = step & w & ~prev_q[1];
  wire win_fall = step & ~w & prev_q[1];

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) prev_q <= 3'h0;
    else if (!en) prev_q <= 3'h0;
    else if (step) prev_q <= {1'b0, w, s};
  end

  // ****************************************
  // mode decode
  // ****************************************
  smtm_evt_t ev;
  // (RL5) mode selection
  always_comb begin
    ev = '0;
    case (mode_q)
      // (RL7) plain timer
      MD_TIMER: ev.inc = meas_tick;
      // (RL9) gated timer
      MD_GTIMER: begin
        ev.inc = meas_tick & s;
        ev.ld_w = sig_fall;
        ev.done = sig_fall;
      end
      // (RL10) period and duty
      MD_PDUTY: begin
        ev.arm = 1'b1;
        ev.inc = meas_tick;
        ev.start = sig_rise;
        ev.one = sig_rise;
        ev.ld_w = sig_fall;
        ev.ld_p = sig_rise;
        ev.done = sig_rise;
      end
      // (RL12) high and low times
      MD_HILO: begin
        ev.arm = 1'b1;
        ev.inc = meas_tick;
        ev.start = sig_rise;
        ev.zero = sig_rise | sig_fall;
        ev.ld_w = sig_fall;
        ev.ld_p = sig_rise;
        ev.done = sig_rise;
      end
      // (RL13) window duration
      MD_WMEAS: begin
        ev.arm = 1'b1;
        ev.inc = meas_tick;
        ev.start = win_rise;
        ev.zero = win_rise;
        ev.ld_p = win_rise;
        ev.done = win_rise;
      end
      // (RL14) gated window
      MD_GWMEAS: begin
        ev.arm = 1'b1;
        ev.inc = meas_tick & s;
        ev.start = win_rise;
        ev.zero = win_rise;
        ev.ld_p = win_rise;
        ev.done = win_rise;
      end
      // (RL15) (RL16) time of flight
      MD_TOF: begin
        ev.arm = 1'b1;
        ev.inc = meas_tick;
        ev.start = win_rise;
        ev.zero = sig_rise | win_rise;
        ev.ld_w = win_rise & ~sig_rise;
        ev.ld_p = sig_rise;
        ev.done = sig_rise;
      end
      // (RL17) (RL18) capture, no edge-driven reset; period match clears unless halt_at_match
      MD_CAPT: begin
        ev.inc = meas_tick;
        ev.ld_p = win_rise;
        ev.ld_w = win_fall;
        ev.done = win_rise;
      end
      // (RL19) signal clocked counter
      MD_CNT: begin
        ev.inc = sig_rise;
        ev.ld_w = win_rise;
        ev.done = win_rise;
      end
      // (RL20) gated counter
      MD_GCNT: begin
        ev.arm = 1'b1;
        ev.inc = sig_rise & w;
        ev.start = win_rise;
        ev.ld_w = win_fall;
        ev.done = win_fall;
      end
      // (RL21) windowed counter
      MD_WCNT: begin
        ev.arm = 1'b1;
        ev.inc = sig_rise;
        ev.start = win_rise;
        ev.ld_w = win_fall;
        ev.ld_p = win_rise;
        ev.done = win_rise;
      end
      default: ev = '0;
    endcase
  end

  wire legal = (mode_q <= MD_WCNT);
  wire run = (state_q == ST_RUN);
  wire act = run | (state_q == ST_WAIT);
  wire inc = run & ev.inc;
  wire ld_w = run & ev.ld_w;
  wire ld_p = run & ev.ld_p;
  wire done = run & ev.done;
  wire at_lim = (cnt_q == lim_q);
  wire match = inc & at_lim;
  wire [CNT_W-1:0] cnt_inc = short_q ? CNT_W'(cnt_q[SHORT_W-1:0] + 16'h0001) : cnt_q + 1'b1;

  // ****************************************
  // acquisition state machine
  // ****************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (legal) state_d = ev.arm ? ST_WAIT : ST_RUN;
      ST_WAIT: if (ev.start) state_d = ST_RUN;
      // (RL1) (RL11) single acquisition ends
      ST_RUN: if (done && !repeat_q) state_d = ST_IDLE;
        else if (done && mode_q == MD_TOF) state_d = ST_WAIT;
      default: state_d = ST_IDLE;
    endcase
    // (RL25) disable drops all state
    if (!en || !go_q) state_d = ST_IDLE;
  end

  // ****************************************
  // counter
  // ****************************************
  always_comb begin
    cnt_d = cnt_q;
    if (wr_cnt) cnt_d = pwdata[CNT_W-1:0];
    else if (man_rst) cnt_d = '0;
    else if (act && ev.one) cnt_d = CNT_W'(1);
    else if (act && ev.zero) cnt_d = '0;
    // (RL8) (RL24) period match
    else if (match) cnt_d = c0_q.halt_at_match ? cnt_q : '0;
    // (RL4) 16-bit wrap option
    else if (inc) cnt_d = cnt_inc;
  end

  // (RL22) set beats a software clear
  always_comb begin
    flags_d = flags_q;
    if (wr_flg) flags_d = flags_d & ~pwdata[2:0];
    flags_d[FL_WIDTH] = flags_d[FL_WIDTH] | ld_w;
    flags_d[FL_PERIOD] = flags_d[FL_PERIOD] | ld_p;
    flags_d[FL_MATCH] = flags_d[FL_MATCH] | match;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      flags_q <= 3'h0;
      irq_q <= 3'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      flags_q <= flags_d;
      // (RL23) registered interrupt outputs
      irq_q <= flags_q & allow_q;
    end
  end

  // capture latches
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wid_q <= '0;
      per_q <= '0;
    end else begin
      if (ld_w || man_cpw) wid_q <= cnt_q;
      if (ld_p || man_cpr) per_q <= cnt_q;
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      c0_q <= '0;
      go_q <= 1'b0;
      repeat_q <= 1'b0;
      short_q <= 1'b0;
      mode_q <= 4'h0;
      lim_q <= CNT_W'(LIMIT_RST);
      allow_q <= 3'h0;
    end else begin
      if (wr_c0) c0_q <= pwdata[6:0];
      if (wr_c1) begin
        go_q <= pwdata[C1_GO];
        repeat_q <= pwdata[C1_REPEAT];
        short_q <= pwdata[C1_SHORT];
        mode_q <= pwdata[3:0];
      // (RL1) (RL2) single clears run bit
      end else if (done && !repeat_q) begin
        go_q <= 1'b0;
      end
      if (wr_lim) lim_q <= pwdata[CNT_W-1:0];
      if (wr_alw) allow_q <= pwdata[2:0];
    end
  end

  // ****************************************
  // apb read path
  // ****************************************
  always_comb begin
    rd_mux = 32'h0;
    case (paddr)
      OFS_CTRL0: rd_mux = 32'(c0_q);
      OFS_CTRL1: rd_mux = {24'h0, go_q, repeat_q, short_q, 1'b0, mode_q};
      OFS_STAT: rd_mux = {29'h0, run, w, s};
      OFS_COUNT: rd_mux = 32'(cnt_q);
      OFS_WIDTH: rd_mux = 32'(wid_q);
      OFS_PERIOD: rd_mux = 32'(per_q);
      OFS_LIMIT: rd_mux = 32'(lim_q);
      OFS_FLAGS: rd_mux = {29'h0, flags_q};
      OFS_ALLOW: rd_mux = {29'h0, allow_q};
      default: rd_mux = 32'h0;
    endcase
  end

  // one wait-free access phase; read data is sampled in setup
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit;
      if (setup) prdata_q <= pwrite ? 32'h0 : rd_mux;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign width_capture_irq = irq_q[FL_WIDTH];
  assign period_capture_irq = irq_q[FL_PERIOD];
  assign match_irq = irq_q[FL_MATCH];

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_single_stop;
    done && !repeat_q && !wr_c1 |=> !go_q && state_q == ST_IDLE;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single acquisition kept running"); // (RL1)

  property p_repeat_keep;
    done && repeat_q && !wr_c1 && en |=> go_q;
  endproperty
  a_repeat_keep: assert property (p_repeat_keep) else $error("repeat acquisition lost run bit"); // (RL2)

  property p_timer_go;
    mode_q == MD_TIMER && go_q && !wr_c1 |=> go_q;
  endproperty
  a_timer_go: assert property (p_timer_go) else $error("timer mode changed run bit"); // (RL7)

  property p_match_zero;
    mode_q == MD_TIMER && match && !c0_q.halt_at_match && !cnt_sw |=> cnt_q == '0 && flags_q[FL_MATCH];
  endproperty
  a_match_zero: assert property (p_match_zero) else $error("match did not reset and flag"); // (RL8)

  property p_match_halt;
    mode_q == MD_TIMER && match && c0_q.halt_at_match && !cnt_sw |=> cnt_q == lim_q && flags_q[FL_MATCH];
  endproperty
  a_match_halt: assert property (p_match_halt) else $error("halt at match did not hold"); // (RL24)

  property p_gate_width;
    mode_q == MD_GTIMER && run && sig_fall && !man_cpw |=> wid_q == $past(cnt_q);
  endproperty
  a_gate_width: assert property (p_gate_width) else $error("gated timer width not loaded"); // (RL9)

  property p_pd_rise;
    mode_q == MD_PDUTY && run && sig_rise && !cnt_sw |=> per_q == $past(cnt_q) && cnt_q == CNT_W'(1);
  endproperty
  a_pd_rise: assert property (p_pd_rise) else $error("period rise did not load and restart"); // (RL10)

  property p_capt_mono;
    mode_q == MD_CAPT && !cnt_sw && !short_q && !(match && !c0_q.halt_at_match) |=> cnt_q >= $past(cnt_q);
  endproperty
  a_capt_mono: assert property (p_capt_mono) else $error("capture counter reset by hardware"); // (RL18)

  property p_disable;
    !en |=> state_q == ST_IDLE && ps_cnt_q == 3'h0;
  endproperty
  a_disable: assert property (p_disable) else $error("disable left state active"); // (RL25)

  property p_width_irq;
    ld_w && allow_q[FL_WIDTH] && !wr_alw |-> ##2 width_capture_irq;
  endproperty
  a_width_irq: assert property (p_width_irq) else $error("width capture interrupt missing"); // (RL22)

endmodule

// ### rtl/smtm_pkg.sv
// constants and types of the signal measurement timer engine
// assumes a 32-bit apb slave and one 20 MHz reference clock
// Operation
// (RL1) single acquisition stops counter, clears run bit
// (RL2) repeat acquisition keeps running, overwrites captures
// (RL3) polarity bits invert window, signal, clock
// (RL4) counter selectable as 16 or 24 bits
// (RL5) mode field selects eleven modes
// (RL6) modes 0-7 synchronous, 8-10 signal clocked
// (RL7) timer mode counts while run, no capture
// (RL8) timer period match resets counter, flags match
// (RL9) gated timer counts while signal; fall loads width
// (RL10) period/duty: fall width, rise period, count one
// (RL11) period/duty single: rise clears run bit
// (RL12) high/low: both edges capture and restart
// (RL13) windowed measure: window rises load period, reset
// (RL14) gated window: count while signal, rises load
// (RL15) flight: window starts, signal rise loads period
// (RL16) flight: second window rise loads width, resets
// (RL17) capture: window rise period, fall width
// (RL18) capture: only software clears the counter; code also clears it on period match unless halt_at_match
// (RL19) counter: signal pulses count, window rise width
// (RL20) gated counter: count from rise, fall width
// (RL21) windowed counter: fall width, later rises period
// (RL22) three flags, each with its own enable
// (RL23) capture triggers synchronised before interrupt output
// (RL24) halt at match holds limit, else zero
// (RL25) enable clear resets state, keeps registers
// (RL26) inputs synchronised, edges from synchronised samples
package smtm_pkg;

  localparam int unsigned CNT_W_DEF = 24;
  localparam int unsigned SHORT_W = 16;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_WIDTH = 8'h10;
  localparam logic [7:0] OFS_PERIOD = 8'h14;
  localparam logic [7:0] OFS_LIMIT = 8'h18;
  localparam logic [7:0] OFS_FLAGS = 8'h1C;
  localparam logic [7:0] OFS_ALLOW = 8'h20;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int unsigned C1_GO = 7;
  localparam int unsigned C1_REPEAT = 6;
  localparam int unsigned C1_SHORT = 5;
  localparam int unsigned ST_CPRUP = 7;
  localparam int unsigned ST_CPWUP = 6;
  localparam int unsigned ST_RST = 5;
  localparam int unsigned ST_TS = 2;
  localparam int unsigned ST_WS = 1;
  localparam int unsigned ST_AS = 0;
  localparam int unsigned FL_WIDTH = 0;
  localparam int unsigned FL_PERIOD = 1;
  localparam int unsigned FL_MATCH = 2;
  localparam logic [23:0] LIMIT_RST = 24'hFFFFFF;

  typedef enum logic [3:0] {
    MD_TIMER = 4'h0, MD_GTIMER = 4'h1, MD_PDUTY = 4'h2, MD_HILO = 4'h3,
    MD_WMEAS = 4'h4, MD_GWMEAS = 4'h5, MD_TOF = 4'h6, MD_CAPT = 4'h7,
    MD_CNT = 4'h8, MD_GCNT = 4'h9, MD_WCNT = 4'hA
  } smtm_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } smtm_state_t;

  // control register 0, bits [6:0]
  typedef struct packed {
    logic enable;
    logic halt_at_match;
    logic window_invert;
    logic signal_invert;
    logic clock_invert;
    logic [1:0] prescale;
  } smtm_ctrl0_t;

  // per-mode decode of what the current edges do
  typedef struct packed {
    logic arm;
    logic inc;
    logic start;
    logic one;
    logic zero;
    logic ld_p;
    logic ld_w;
    logic done;
  } smtm_evt_t;

endpackage

// ### test/smtm_src_model.sv
// far-side sources of the measurement engine: measurement clock, signal and window pins
// assumes the bench calls its tasks in sequence; pins are slow next to ref_clk
`timescale 1ns/1ps
module smtm_src_model (
  output logic meas_clk_in,
  output logic measured_signal_input,
  output logic window_input
);
  // ****************************************
  // free-running measurement clock
  // ****************************************
  // period 220 ns, below ref_clk/2, phase unrelated to ref_clk
  initial begin
    meas_clk_in = 1'h0;
    measured_signal_input = 1'h0;
    window_input = 1'h0;
    #37;
    forever #110 meas_clk_in = ~meas_clk_in;
  end

  // ****************************************
  // pin stimulus
  // ****************************************
  // spacing survives synchroniser
  task automatic sig_pulses(input int n);
    repeat (n) begin
      #200 measured_signal_input = 1'h1;
      #200 measured_signal_input = 1'h0;
    end
    #300;
  endtask

  task automatic sig_level(input logic l);
    measured_signal_input = l;
    #2000;
  endtask

  // settle time lets the edge pass both sync stages
  task automatic win(input logic l);
    #300 window_input = l;
    #400;
  endtask
endmodule

// ### test/smtm_core_tb.sv
// self-checking bench of the measurement engine over apb
// assumes one-cycle apb access and the register map of smtm_pkg
`timescale 1ns/1ps
module smtm_core_tb;
  import smtm_pkg::*;
  typedef struct packed {
    logic [7:0] c0;
    logic [7:0] c1;
    logic [3:0] p0;
    logic [3:0] p1;
    logic [3:0] p2;
    logic [23:0] w;
    logic [23:0] p;
    logic [2:0] f;
    logic go;
  } smtm_row_t;
  logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, w_v, p_v;
  logic meas_clk_in, measured_signal_input, window_input;
  logic width_capture_irq, period_capture_irq, match_irq;
  int miscompares, n_checks;
  // synchronous modes driven by one edge sequence, and the flags each must raise
  logic [3:0] sm_mode [5] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6};
  logic [2:0] sm_flags [5] = '{3'h1, 3'h3, 3'h2, 3'h2, 3'h2};
  // pulses before window rise, while high, after fall; then a second rise
  smtm_row_t rows [5] = '{
    '{8'h40, 8'h4B, 4'h2, 4'h2, 4'h2, 24'h0, 24'h0, 3'h0, 1'h1},
    '{8'h40, 8'h08, 4'h4, 4'h2, 4'h1, 24'h4, 24'h0, 3'h1, 1'h0},
    '{8'h40, 8'h49, 4'h2, 4'h3, 4'h2, 24'h3, 24'h0, 3'h1, 1'h1},
    '{8'h40, 8'h4A, 4'h2, 4'h3, 4'h4, 24'h3, 24'h7, 3'h3, 1'h1},
    '{8'h50, 8'h08, 4'h2, 4'h3, 4'h1, 24'h5, 24'h7, 3'h1, 1'h0}
  };

  smtm_core smtm_core_i (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .measured_signal_input(measured_signal_input), .window_input(window_input),
    .meas_clk_in(meas_clk_in), .width_capture_irq(width_capture_irq),
    .period_capture_irq(period_capture_irq), .match_irq(match_irq));
  smtm_src_model smtm_src_model_i (.meas_clk_in(meas_clk_in),
    .measured_signal_input(measured_signal_input), .window_input(window_input));

  // ****************************************
  // apb master and checks
  // ****************************************
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); apb(1'h1, a, d); endtask
  task rd(input logic [7:0] a); apb(1'h0, a, 32'h0); endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task tally_and_finish;
    if (miscompares == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  // whole run is near 120 us; a hang stops it here
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish;
  end

  initial begin
    arst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'h1;
    // ****************************************
    // reset values and refused address
    // ****************************************
    rd(OFS_LIMIT); chk(q, 32'h00FFFFFF);
    rd(OFS_CTRL1); chk(q, 32'h0);
    rd(8'h24); chk({q[30:0], err}, 32'h1);
    wr(OFS_ALLOW, 32'h7);
    // ****************************************
    // counter modes and reserved mode, one row each; mode 8 again with window inverted
    // ****************************************
    foreach (rows[i]) begin
      wr(OFS_CTRL1, 32'h0);
      smtm_src_model_i.win(1'h0);
      wr(OFS_CTRL0, {24'h0, rows[i].c0});
      wr(OFS_COUNT, 32'h0);
      wr(OFS_FLAGS, 32'h7);
      wr(OFS_CTRL1, {24'h0, rows[i].c1 | 8'h80});
      smtm_src_model_i.sig_pulses(rows[i].p0);
      smtm_src_model_i.win(1'h1);
      smtm_src_model_i.sig_pulses(rows[i].p1);
      smtm_src_model_i.win(1'h0);
      smtm_src_model_i.sig_pulses(rows[i].p2);
      smtm_src_model_i.win(1'h1);
      rd(OFS_WIDTH); chk(q, {8'h0, rows[i].w});
      rd(OFS_PERIOD); chk(q, {8'h0, rows[i].p});
      rd(OFS_FLAGS); chk(q, {29'h0, rows[i].f});
      chk({match_irq, period_capture_irq, width_capture_irq}, rows[i].f);
      rd(OFS_CTRL1); chk(q[7], rows[i].go);
    end
    // ****************************************
    // capture mode: window edges never reset the counter
    // ****************************************
    wr(OFS_CTRL1, 32'h0);
    smtm_src_model_i.win(1'h0);
    wr(OFS_CTRL0, 32'h40);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_FLAGS, 32'h7);
    wr(OFS_CTRL1, 32'hC7);
    smtm_src_model_i.win(1'h1);
    smtm_src_model_i.win(1'h0);
    rd(OFS_WIDTH); w_v = q;
    rd(OFS_PERIOD); p_v = q;
    rd(OFS_COUNT);
    chk(p_v != 0 && p_v < w_v && w_v < q, 1);
    rd(OFS_FLAGS); chk(q, 32'h3);
    // ****************************************
    // period and duty, single acquisition
    // ****************************************
    wr(OFS_CTRL1, 32'h0);
    wr(OFS_FLAGS, 32'h7);
    wr(OFS_CTRL1, 32'h82);
    smtm_src_model_i.sig_level(1'h1);
    smtm_src_model_i.sig_level(1'h0);
    smtm_src_model_i.sig_level(1'h1);
    smtm_src_model_i.sig_level(1'h0);
    rd(OFS_CTRL1); chk(q[7], 1'h0);
    rd(OFS_WIDTH); w_v = q;
    rd(OFS_PERIOD);
    chk(w_v != 0 && q > w_v, 1);
    rd(OFS_FLAGS); chk(q, 32'h3);
    // ****************************************
    // timer mode, period match with and without halt
    // ****************************************
    wr(OFS_CTRL1, 32'h0);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_LIMIT, 32'h3);
    wr(OFS_FLAGS, 32'h7);
    wr(OFS_CTRL0, 32'h60);
    wr(OFS_CTRL1, 32'hC0);
    smtm_src_model_i.win(1'h1);
    smtm_src_model_i.sig_level(1'h1);
    rd(OFS_COUNT); chk(q, 32'h3);
    rd(OFS_FLAGS); chk(q[2], 1'h1);
    chk(match_irq, 1'h1);
    rd(OFS_CTRL1); chk(q[7], 1'h1);
    wr(OFS_CTRL0, 32'h40);
    smtm_src_model_i.sig_level(1'h0);
    rd(OFS_COUNT); chk(q <= 32'h3, 1);
    // enable cleared keeps register contents
    wr(OFS_CTRL0, 32'h0);
    rd(OFS_LIMIT); chk(q, 32'h3);
    // ****************************************
    // synchronous edge modes, repeat acquisition
    // ****************************************
    wr(OFS_LIMIT, 32'hFFFFFF);
    wr(OFS_CTRL0, 32'h40);
    smtm_src_model_i.win(1'h0);
    foreach (sm_mode[i]) begin
      wr(OFS_CTRL1, 32'h0);
      wr(OFS_FLAGS, 32'h7);
      wr(OFS_CTRL1, {24'h0, 4'hC, sm_mode[i]});
      smtm_src_model_i.sig_level(1'h1);
      smtm_src_model_i.win(1'h1);
      smtm_src_model_i.sig_level(1'h0);
      smtm_src_model_i.win(1'h0);
      smtm_src_model_i.sig_level(1'h1);
      smtm_src_model_i.win(1'h1);
      smtm_src_model_i.sig_level(1'h0);
      smtm_src_model_i.win(1'h0);
      rd(OFS_FLAGS); chk(q, {29'h0, sm_flags[i]});
    end
    tally_and_finish;
  end
endmodule
